// file: shared/scp_params.svh
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// Serial register addresses
`define SCP_ADDR_CFG       13'h0000
`define SCP_ADDR_ID0       13'h0002
`define SCP_ADDR_ID1       13'h0003
`define SCP_ADDR_RDSEL     13'h0004
`define SCP_ADDR_UPD       13'h0005
`define SCP_ADDR_LAST      13'h0509
`define SCP_LIVE_BASE      13'h0010
`define SCP_LIVE_NUM       13'h0004
`define SCP_USER_BASE      13'h0100
`define SCP_USER_NUM       13'h0010

// Identification bytes, values arbitrary
`define SCP_ID0_VAL        8'h5a
`define SCP_ID1_VAL        8'h01

// Configuration byte layout, mirrored nibbles
`define SCP_CFG_PIN_LO     0
`define SCP_CFG_PIN_HI     7
`define SCP_CFG_LSB_LO     1
`define SCP_CFG_LSB_HI     6
`define SCP_CFG_SRST_LO    2
`define SCP_CFG_SRST_HI    5
`define SCP_CFG_FIXED      8'h18
`define SCP_FLAG_BIT       0

// Instruction word layout
`define SCP_INS_RNW        15
`define SCP_INS_LEN_HI     14
`define SCP_INS_LEN_LO     13
`define SCP_INS_ADDR_HI    12
`define SCP_LEN_STREAM     2'h3
`define SCP_BIT_FIRST      3'h0
`define SCP_BIT_LAST       3'h7
`define SCP_LEFT_NONE      2'h0

// Avalon-MM byte offsets
`define SCP_AV_STATUS      8'h00
`define SCP_AV_CTRL        8'h04
`define SCP_AV_DATA_LO     8'h40
`define SCP_AV_DATA_HI     8'h7c

// Synchroniser lanes
`define SCP_SY_SCLK        0
`define SCP_SY_SEL         1
`define SCP_SY_SDI         2
`define SCP_SY_UPD         3
`define SCP_SY_DAC         4
`define SCP_SY_W           5

`endif

// file: shared/scp_pkg.sv
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_IDLE  = 2'b00,
        SCP_INSTR = 2'b01,
        SCP_DATA  = 2'b10
    } scp_state_t;
endpackage

// file: hdl/scp_serial_port.sv
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "scp_params.svh"

// Notes on behaviour
// - Write bits captured on serial clock rise, read bits launched on its fall.
// - Shared data pin by default; config bit 0 moves read data to separate pin.
// - With select high both data outputs are released to high impedance.
// - Lengths 1-3 bytes may stall on byte boundaries and resume on select low.
// - Master aborts a stall by finishing or pulsing 1 to 7 serial clocks.
// - Select rising mid-byte ends transfer, drops partial data, resets the engine.
// - Streaming length moves any byte count with auto address step until select rises.
// - Each cycle opens with a 16-bit instruction on first 16 rising edges.
// - Read-not-write bit clear: following bytes, count by length code, are written.
// - Read-not-write bit set: N bytes shifted out, streaming runs indefinitely.
// - Buffered writes wait in shadow until update pin or update register bit.
// - Live registers take written values at once.
// - Read-only registers ignore writes.
// - Self-clearing bits drop back by themselves after acting.
// - Reads return active values, or shadow values when register 4 bit 0 set.
// - Addresses 0x0000 to 0x0509 decoded, 16-bit instructions only.
// - Updates reaching the core complete only while the DAC clock runs.
// - Instruction: bit 15 direction, bits 14-13 length, bits 12-0 start address.
// - MSB-first order steps address down, LSB-first order steps it up.
// - LSB-first bit is buffered; after update all bits use the new order.
module scp_serial_port (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_clk_en,
    input  wire logic        i_sclk,
    input  wire logic        i_select_n,
    input  wire logic        i_sdio,
    input  wire logic        i_io_update,
    input  wire logic        i_dac_clk_ok,
    output logic             o_sdio,
    output logic             o_sdio_oe,
    output logic             o_separate_data_out,
    output logic             o_separate_data_out_oe,
    input  wire logic [7:0]  i_av_address,
    input  wire logic        i_av_read,
    input  wire logic        i_av_write,
    input  wire logic [3:0]  i_av_byteenable,
    input  wire logic [31:0] i_av_writedata,
    output logic [31:0]      o_av_readdata,
    output logic             o_av_waitrequest
);

    logic [`SCP_SY_W-1:0]  sy1_reg;
    logic [`SCP_SY_W-1:0]  sy2_reg;
    logic                  sclk_d_reg;
    logic                  sel_d_reg;
    logic                  upd_d_reg;
    scp_pkg::scp_state_t   state_reg;
    logic [2:0]            bit_cnt_reg;
    logic [15:0]           sr_reg;
    logic                  rnw_reg;
    logic [1:0]            len_reg;
    logic [1:0]            left_reg;
    logic [12:0]           addr_reg;
    logic [7:0]            out_sr_reg;
    logic                  out_bit_reg;
    logic                  pin_en_reg;
    logic                  sep_en_reg;
    logic                  output_pin_enable_reg;
    logic                  lsb_shd_reg;
    logic                  lsb_act_reg;
    logic                  rdsel_reg;
    logic                  pending_reg;
    logic [15:0][7:0]      user_shd_reg;
    logic [15:0][7:0]      user_act_reg;
    logic [3:0][7:0]       live_reg;
    logic                  waitreq_reg;
    logic [31:0]           rdata_reg;

    logic                  sel_n;
    logic                  sel_rise;
    logic                  shift_en;
    logic                  fall_en;
    logic                  upd_rise;
    logic                  dac_ok;
    logic [15:0]           nxt_sr;
    logic [7:0]            in_byte;
    logic [12:0]           ins_addr;
    logic [12:0]           nxt_addr;
    logic                  data_done;
    logic                  wr_fire;
    logic [12:0]           wr_uoff;
    logic [12:0]           wr_loff;
    logic                  wr_user;
    logic                  wr_live;
    logic                  soft_rst;
    logic                  apply;
    logic                  av_req;
    logic                  av_upd;
    logic [31:0]           av_rval;

    function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
        step_addr = lsb ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
    endfunction
    function automatic logic [7:0] rd_byte(input logic [12:0] a);
        logic [12:0] uo;
        logic [12:0] lo;
        logic        lsb_v;
        uo      = 13'(a - `SCP_USER_BASE);
        lo      = 13'(a - `SCP_LIVE_BASE);
        lsb_v   = rdsel_reg ? lsb_shd_reg : lsb_act_reg;
        rd_byte = 8'h00;
        if (a == `SCP_ADDR_CFG) begin
            rd_byte                  = `SCP_CFG_FIXED;
            rd_byte[`SCP_CFG_PIN_LO] = output_pin_enable_reg;
            rd_byte[`SCP_CFG_PIN_HI] = output_pin_enable_reg;
            rd_byte[`SCP_CFG_LSB_LO] = lsb_v;
            rd_byte[`SCP_CFG_LSB_HI] = lsb_v;
        end else if (a == `SCP_ADDR_ID0) begin
            rd_byte = `SCP_ID0_VAL;
        end else if (a == `SCP_ADDR_ID1) begin
            rd_byte = `SCP_ID1_VAL;
        end else if (a == `SCP_ADDR_RDSEL) begin
            rd_byte[`SCP_FLAG_BIT] = rdsel_reg;
        end else if (uo < `SCP_USER_NUM) begin
            rd_byte = rdsel_reg ? user_shd_reg[uo[3:0]] : user_act_reg[uo[3:0]];
        end else if (lo < `SCP_LIVE_NUM) begin
            rd_byte = live_reg[lo[1:0]];
        end
    endfunction

    // Two-flop synchronisers for every pin input
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sy1_reg <= 5'h02;
            sy2_reg <= 5'h02;
        end else if (i_clk_en) begin
            sy1_reg <= {i_dac_clk_ok, i_io_update, i_sdio, i_select_n, i_sclk};
            sy2_reg <= sy1_reg;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sclk_d_reg <= 1'b0;
            sel_d_reg  <= 1'b1;
            upd_d_reg  <= 1'b0;
        end else if (i_clk_en) begin
            sclk_d_reg <= sy2_reg[`SCP_SY_SCLK];
            sel_d_reg  <= sy2_reg[`SCP_SY_SEL];
            upd_d_reg  <= sy2_reg[`SCP_SY_UPD];
        end
    end

    always_comb begin
        sel_n    = sy2_reg[`SCP_SY_SEL];
        dac_ok   = sy2_reg[`SCP_SY_DAC];
        sel_rise = sel_n & ~sel_d_reg;
        upd_rise = sy2_reg[`SCP_SY_UPD] & ~upd_d_reg;
        shift_en = ~sel_n & sy2_reg[`SCP_SY_SCLK] & ~sclk_d_reg;
        fall_en  = ~sel_n & ~sy2_reg[`SCP_SY_SCLK] & sclk_d_reg;
        nxt_sr   = lsb_act_reg ? {sy2_reg[`SCP_SY_SDI], sr_reg[15:1]}
                               : {sr_reg[14:0], sy2_reg[`SCP_SY_SDI]};
        in_byte  = lsb_act_reg ? nxt_sr[15:8] : nxt_sr[7:0];
        ins_addr = nxt_sr[`SCP_INS_ADDR_HI:0];
        nxt_addr = step_addr(addr_reg, lsb_act_reg);
        data_done = shift_en && !sel_rise && state_reg == scp_pkg::SCP_DATA
                    && bit_cnt_reg == `SCP_BIT_LAST;
        wr_fire  = data_done && !rnw_reg;
        wr_uoff  = 13'(addr_reg - `SCP_USER_BASE);
        wr_loff  = 13'(addr_reg - `SCP_LIVE_BASE);
        wr_user  = wr_uoff < `SCP_USER_NUM;
        wr_live  = wr_loff < `SCP_LIVE_NUM;
        soft_rst = wr_fire && addr_reg == `SCP_ADDR_CFG
                   && (in_byte[`SCP_CFG_SRST_LO] || in_byte[`SCP_CFG_SRST_HI]);
        apply    = pending_reg && dac_ok;
    end

    // Serial framing engine
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg   <= scp_pkg::SCP_IDLE;
            bit_cnt_reg <= `SCP_BIT_FIRST;
            sr_reg      <= 16'h0000;
            rnw_reg     <= 1'b0;
            len_reg     <= 2'h0;
            left_reg    <= `SCP_LEFT_NONE;
            addr_reg    <= 13'h0000;
            out_sr_reg  <= 8'h00;
            out_bit_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (sel_rise) begin
                if (bit_cnt_reg != `SCP_BIT_FIRST) begin
                    state_reg   <= scp_pkg::SCP_IDLE;
                    bit_cnt_reg <= `SCP_BIT_FIRST;
                    sr_reg      <= 16'h0000;
                end else if (state_reg == scp_pkg::SCP_DATA && len_reg == `SCP_LEN_STREAM) begin
                    state_reg <= scp_pkg::SCP_IDLE;
                end
                // Otherwise a byte-boundary stall: everything holds
            end else if (shift_en) begin
                sr_reg      <= nxt_sr;
                bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
                if (bit_cnt_reg == `SCP_BIT_LAST) begin
                    unique case (state_reg)
                        scp_pkg::SCP_IDLE: begin
                            state_reg <= scp_pkg::SCP_INSTR;
                        end
                        scp_pkg::SCP_INSTR: begin
                            rnw_reg    <= nxt_sr[`SCP_INS_RNW];
                            len_reg    <= nxt_sr[`SCP_INS_LEN_HI:`SCP_INS_LEN_LO];
                            left_reg   <= nxt_sr[`SCP_INS_LEN_HI:`SCP_INS_LEN_LO];
                            addr_reg   <= ins_addr;
                            out_sr_reg <= rd_byte(ins_addr);
                            state_reg  <= scp_pkg::SCP_DATA;
                        end
                        scp_pkg::SCP_DATA: begin
                            addr_reg   <= nxt_addr;
                            out_sr_reg <= rd_byte(nxt_addr);
                            if (len_reg != `SCP_LEN_STREAM) begin
                                if (left_reg == `SCP_LEFT_NONE) begin
                                    state_reg <= scp_pkg::SCP_IDLE;
                                end else begin
                                    left_reg <= 2'(left_reg - 2'h1);
                                end
                            end
                        end
                    endcase
                end
            end else if (fall_en && state_reg == scp_pkg::SCP_DATA && rnw_reg) begin
                out_bit_reg <= lsb_act_reg ? out_sr_reg[0] : out_sr_reg[7];
                out_sr_reg  <= lsb_act_reg ? {1'b0, out_sr_reg[7:1]} : {out_sr_reg[6:0], 1'b0};
            end
        end
    end

    // Pin drivers
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_en_reg <= 1'b0;
            sep_en_reg <= 1'b0;
        end else if (i_clk_en) begin
            pin_en_reg <= !sel_n && state_reg == scp_pkg::SCP_DATA && rnw_reg
                          && !output_pin_enable_reg;
            sep_en_reg <= !sel_n && state_reg == scp_pkg::SCP_DATA && rnw_reg
                          && output_pin_enable_reg;
        end
    end

    // Register banks: shadow, active, live
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            output_pin_enable_reg <= 1'b0;
            lsb_shd_reg           <= 1'b0;
            lsb_act_reg           <= 1'b0;
            rdsel_reg             <= 1'b0;
            pending_reg           <= 1'b0;
            user_shd_reg          <= '0;
            user_act_reg          <= '0;
            live_reg              <= '0;
        end else if (i_clk_en) begin
            if (soft_rst) begin
                output_pin_enable_reg <= 1'b0;
                lsb_shd_reg           <= 1'b0;
                lsb_act_reg           <= 1'b0;
                rdsel_reg             <= 1'b0;
                pending_reg           <= 1'b0;
                user_shd_reg          <= '0;
                user_act_reg          <= '0;
                live_reg              <= '0;
            end else begin
                if (apply) begin
                    user_act_reg <= user_shd_reg;
                    lsb_act_reg  <= lsb_shd_reg;
                end
                // New requests win over the clear from a completed update
                pending_reg <= (pending_reg && !apply) || upd_rise || av_upd
                               || (wr_fire && addr_reg == `SCP_ADDR_UPD
                                   && in_byte[`SCP_FLAG_BIT]);
                if (wr_fire) begin
                    if (addr_reg == `SCP_ADDR_CFG) begin
                        output_pin_enable_reg <= in_byte[`SCP_CFG_PIN_LO] | in_byte[`SCP_CFG_PIN_HI];
                        lsb_shd_reg <= in_byte[`SCP_CFG_LSB_LO] | in_byte[`SCP_CFG_LSB_HI];
                    end else if (addr_reg == `SCP_ADDR_RDSEL) begin
                        rdsel_reg <= in_byte[`SCP_FLAG_BIT];
                    end else if (wr_user) begin
                        user_shd_reg[wr_uoff[3:0]] <= in_byte;
                    end else if (wr_live) begin
                        live_reg[wr_loff[1:0]] <= in_byte;
                    end
                end
            end
        end
    end
    // Avalon-MM slave, answers one cycle after the request
    always_comb begin
        av_req  = i_av_read | i_av_write;
        av_upd  = i_av_write && !waitreq_reg && i_av_address == `SCP_AV_CTRL
                  && i_av_byteenable[0] && i_av_writedata[`SCP_FLAG_BIT];
        av_rval = 32'h0000_0000;
        if (i_av_address == `SCP_AV_STATUS) begin
            av_rval = {27'h0, sel_n && state_reg != scp_pkg::SCP_IDLE, pending_reg,
                       output_pin_enable_reg, lsb_act_reg, state_reg != scp_pkg::SCP_IDLE};
        end else if (i_av_address >= `SCP_AV_DATA_LO && i_av_address <= `SCP_AV_DATA_HI
                     && i_av_address[1:0] == 2'h0) begin
            av_rval = {24'h0, user_act_reg[i_av_address[5:2]]};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            waitreq_reg <= 1'b1;
            rdata_reg   <= 32'h0000_0000;
        end else if (i_clk_en) begin
            waitreq_reg <= !(av_req && waitreq_reg);
            if (i_av_read && waitreq_reg) begin
                rdata_reg <= av_rval;
            end
        end
    end
    always_comb begin
        o_sdio                 = out_bit_reg;
        o_sdio_oe              = pin_en_reg;
        o_separate_data_out    = out_bit_reg;
        o_separate_data_out_oe = sep_en_reg;
        o_av_readdata          = rdata_reg;
        o_av_waitrequest       = waitreq_reg;
    end
    AST_HIZ_DESELECTED: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && sel_n) |=> (!o_sdio_oe && !o_separate_data_out_oe))
        else $error("data pins driven while deselected");
    AST_PIN_ONLY_READ: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (o_sdio_oe && $past(i_clk_en)) |-> $past(rnw_reg && state_reg == scp_pkg::SCP_DATA
                                                 && !output_pin_enable_reg))
        else $error("shared pin driven outside read data phase");
    AST_MIDBYTE_RESET: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && sel_rise && bit_cnt_reg != `SCP_BIT_FIRST)
        |=> (state_reg == scp_pkg::SCP_IDLE && bit_cnt_reg == `SCP_BIT_FIRST))
        else $error("mid-byte deselect did not reset engine");
    AST_STALL_HOLDS: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && sel_rise && bit_cnt_reg == `SCP_BIT_FIRST && len_reg != `SCP_LEN_STREAM)
        |=> ($stable(state_reg) && $stable(addr_reg) && $stable(left_reg)))
        else $error("byte-boundary stall lost transfer state");
    AST_STREAM_END: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && sel_rise && bit_cnt_reg == `SCP_BIT_FIRST
         && state_reg == scp_pkg::SCP_DATA && len_reg == `SCP_LEN_STREAM)
        |=> state_reg == scp_pkg::SCP_IDLE)
        else $error("stream not ended by deselect");
    AST_ADDR_STEP: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && data_done)
        |=> addr_reg == ($past(lsb_act_reg) ? 13'($past(addr_reg) + 13'h0001)
                                            : 13'($past(addr_reg) - 13'h0001)))
        else $error("address stepped the wrong way");
    AST_LIVE_NOW: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && wr_fire && wr_live && !soft_rst && !wr_user)
        |=> live_reg[$past(wr_loff[1:0])] == $past(in_byte))
        else $error("live register not written at once");
    AST_SHADOW_WAITS: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && !apply && !soft_rst) |=> $stable(user_act_reg))
        else $error("active bank changed without update");
    AST_UPDATE_APPLIES: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && apply && !soft_rst) |=> user_act_reg == $past(user_shd_reg))
        else $error("update did not copy shadow bank");
    AST_UPDATE_NEEDS_DAC: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && pending_reg && !dac_ok && !soft_rst) |=> (pending_reg && $stable(lsb_act_reg)))
        else $error("update completed without DAC clock");
    AST_RO_IGNORED: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        (i_clk_en && wr_fire && (addr_reg == `SCP_ADDR_ID0 || addr_reg == `SCP_ADDR_ID1) && !apply)
        |=> ($stable(user_shd_reg) && $stable(live_reg) && $stable(output_pin_enable_reg)))
        else $error("write to read-only address changed state");

endmodule // scp_serial_port

// file: dv/scp_host_model.sv
`timescale 1ns/1ns
module scp_host_model (
    input  wire logic i_core_clk,
    input  wire logic i_rd_line,
    output logic      o_sclk,
    output logic      o_select_n,
    output logic      o_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_sdo = 1'b0;
    end
    // Data set up in the low phase, both sides sample on the rise
    task automatic bit_io(input logic b, output logic r);
        o_sdo <= b;
        repeat (8) @(posedge i_core_clk);
        o_sclk <= 1'b1;
        r = i_rd_line;
        repeat (8) @(posedge i_core_clk);
        o_sclk <= 1'b0;
    endtask
    // nb bits: 16 instruction bits then data, MSB first; nb not byte aligned aborts
    task automatic xfer(input logic [15:0] ins, input int nb, input logic [31:0] wd,
                        input logic stall, output logic [31:0] rd);
        logic r;
        rd = '0;
        @(posedge i_core_clk);
        o_select_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            bit_io(i < 16 ? ins[15-i] : wd[31-(i-16)], r);
            if (i >= 16) rd = {rd[30:0], r};
            if (stall && i % 8 == 7 && i < nb - 1) begin
                o_select_n <= 1'b1;
                repeat (40) @(posedge i_core_clk);
                o_select_n <= 1'b0;
                repeat (8) @(posedge i_core_clk);
            end
        end
        repeat (8) @(posedge i_core_clk);
        o_select_n <= 1'b1;
        o_sdo <= ~o_sdo;
        repeat (16) @(posedge i_core_clk);
    endtask
endmodule // scp_host_model

// file: dv/scp_serial_port_test.sv
`timescale 1ns/1ns
`include "scp_params.svh"
module scp_serial_port_test;
    logic clk = 1'b0, rstn = 1'b0, upd = 1'b0, dac = 1'b1, sep = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic        sclk, seln, hsdo, sd_w, sep_w, rline, s_oe, p_oe, wreq, sdo_a, sdo_b;
    logic        oe_a = 1'b0, oe_b = 1'b0, oe_clr = 1'b0;
    logic [31:0] rdat, q;
    int          fail_count = 0, check_count = 0;
    always #5 clk = ~clk;
    assign sd_w  = s_oe ? sdo_a : hsdo;
    assign sep_w = p_oe ? sdo_b : 1'bz;
    assign rline = sep ? sep_w : sd_w;
    always @(posedge clk) begin
        if (oe_clr) begin
            oe_a <= 1'b0;
            oe_b <= 1'b0;
        end else begin
            if (s_oe === 1'b1) oe_a <= 1'b1;
            if (p_oe === 1'b1) oe_b <= 1'b1;
        end
    end
    scp_serial_port scp_serial_port_i (.i_core_clk(clk), .i_resetn(rstn), .i_clk_en(1'b1),
        .i_sclk(sclk), .i_select_n(seln), .i_sdio(sd_w), .i_io_update(upd), .i_dac_clk_ok(dac),
        .o_sdio(sdo_a), .o_sdio_oe(s_oe), .o_separate_data_out(sdo_b), .o_separate_data_out_oe(p_oe),
        .i_av_address(adr), .i_av_read(rd), .i_av_write(wr), .i_av_byteenable(4'h1),
        .i_av_writedata(wdat), .o_av_readdata(rdat), .o_av_waitrequest(wreq));
    scp_host_model host_i (.i_core_clk(clk), .i_rd_line(rline), .o_sclk(sclk),
        .o_select_n(seln), .o_sdo(hsdo));
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 50) check("waitrequest", 32'h1, 32'h0);
    endtask
    task automatic sw(input logic [12:0] a, input logic [7:0] d);
        logic [31:0] r;
        host_i.xfer({3'b000, a}, 24, {d, 24'h0}, 1'b0, r);
    endtask
    task automatic sr(input logic [12:0] a, input logic [7:0] e, input string n);
        logic [31:0] r;
        host_i.xfer({3'b100, a}, 24, 32'h0, 1'b0, r);
        check(n, {24'h0, r[7:0]}, {24'h0, e});
    endtask
    task automatic t_buffered;
        sw(13'h0100, 8'ha5);
        av(1'b0, 8'h40, 32'h0);
        check("active before update", q, 32'h0);
        sr(13'h0100, 8'h00, "read active");
        sw(13'h0004, 8'h01);
        sr(13'h0100, 8'ha5, "read shadow");
        sw(13'h0004, 8'h00);
        av(1'b1, 8'h04, 32'h1);
        av(1'b0, 8'h40, 32'h0);
        check("active after update", q, 32'ha5);
    endtask
    task automatic t_dac;
        dac <= 1'b0;
        sw(13'h0101, 8'h3c);
        upd <= 1'b1;
        repeat (5) @(posedge clk);
        upd <= 1'b0;
        repeat (10) @(posedge clk);
        av(1'b0, 8'h44, 32'h0);
        check("update held", q, 32'h0);
        dac <= 1'b1;
        repeat (10) @(posedge clk);
        av(1'b0, 8'h44, 32'h0);
        check("pin update", q, 32'h3c);
    endtask
    task automatic t_multi;
        logic [31:0] r;
        host_i.xfer({3'b010, 13'h0103}, 40, 32'h11223300, 1'b1, r);
        host_i.xfer({3'b000, 13'h0104}, 20, 32'hffffffff, 1'b0, r);
        sw(13'h0005, 8'h01);
        sr(13'h0005, 8'h00, "update bit");
        av(1'b0, 8'h50, 32'h0);
        check("aborted byte", q, 32'h0);
        host_i.xfer({3'b111, 13'h0103}, 48, 32'h0, 1'b0, r);
        check("stream read", r, 32'h112233a5);
    endtask
    task automatic t_pins;
        sw(13'h0010, 8'h77);
        sr(13'h0010, 8'h77, "live");
        sw(13'h0002, 8'h00);
        sr(13'h0002, `SCP_ID0_VAL, "read only");
        check("oe idle", {30'h0, s_oe, p_oe}, 32'h0);
        sw(13'h0000, 8'h81);
        sep <= 1'b1;
        oe_clr <= 1'b1;
        @(posedge clk);
        oe_clr <= 1'b0;
        sr(13'h0010, 8'h77, "separate pin");
        check("pin oe", {30'h0, oe_a, oe_b}, 32'h1);
    endtask
    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] v;
        for (int i = 0; i < 8; i++) v[i] = b[7 - i];
        return v;
    endfunction
    function automatic logic [15:0] lsb_ins(input logic [15:0] w);
        return {rev8(w[7:0]), rev8(w[15:8])};
    endfunction
    task automatic t_lsb;
        logic [31:0] r;
        sw(13'h0000, 8'hc3);
        av(1'b1, 8'h04, 32'h1);
        av(1'b0, 8'h00, 32'h0);
        check("lsb status", q, 32'h6);
        host_i.xfer(lsb_ins({3'b001, 13'h0108}), 32, {rev8(8'h12), rev8(8'h34), 16'h0}, 1'b0, r);
        av(1'b1, 8'h04, 32'h1);
        av(1'b0, 8'h60, 32'h0);
        check("lsb first byte", q, 32'h12);
        av(1'b0, 8'h64, 32'h0);
        check("lsb address up", q, 32'h34);
        host_i.xfer(lsb_ins({3'b101, 13'h0108}), 32, 32'h0, 1'b0, r);
        check("lsb read", {16'h0, rev8(r[15:8]), rev8(r[7:0])}, 32'h1234);
        host_i.xfer(lsb_ins({3'b000, 13'h0000}), 24, {8'h24, 24'h0}, 1'b0, r);
        av(1'b0, 8'h00, 32'h0);
        check("soft reset status", q, 32'h0);
        av(1'b0, 8'h60, 32'h0);
        check("soft reset bank", q, 32'h0);
    endtask
    task automatic final_report;
        if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #900000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        av(1'b0, 8'h00, 32'h0);
        check("status reset", q, 32'h0);
        t_buffered();
        t_dac();
        t_multi();
        t_pins();
        t_lsb();
        final_report();
    end
endmodule // scp_serial_port_test
